// ==== core/aip_pkg.sv ====
/*
 * aip_pkg: shared constants of the audio input serial port pair.
 * assumes: both ends and the control port run on one 20 MHz clock.
 */
package aip_pkg;
	// ----------------------------------------------------------------
	// framing formats and word lengths
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_I2S = 2'h0,            // left on frame low, msb one bit late
		FMT_LJ  = 2'h1,            // left on frame high, msb at edge
		FMT_RJ  = 2'h2             // left on frame high, lsb before edge
	} aip_fmt_e;
	localparam logic [1:0] WL_16 = 2'h0;
	localparam logic [1:0] WL_20 = 2'h1;
	localparam logic [1:0] WL_24 = 2'h2;
	// ----------------------------------------------------------------
	// sample rate classes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_32K  = 2'h0,
		RATE_NORM = 2'h1,
		RATE_DBL  = 2'h2,
		RATE_QUAD = 2'h3
	} aip_rate_e;
	// ----------------------------------------------------------------
	// timing in reference cycles of the 20 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 20;
	localparam int MCK_TMO_NS   = 2000;  // master clock silent limit
	localparam int BCK_TMO_NS   = 4000;  // bit clock silent limit
	localparam int FRM_TMO_NS   = 40000; // frame clock silent limit
	localparam int MCK_TMO_CYC  = MCK_TMO_NS * CLK_MHZ / 1000;
	localparam int BCK_TMO_CYC  = BCK_TMO_NS * CLK_MHZ / 1000;
	localparam int FRM_TMO_CYC  = FRM_TMO_NS * CLK_MHZ / 1000;
	// half-frame lengths that separate the rate classes
	localparam logic [10:0] HALF_32K  = 11'h104;  // above: 32 kHz
	localparam logic [10:0] HALF_NORM = 11'h096;  // above: normal
	localparam logic [10:0] HALF_DBL  = 11'h04B;  // above: double
	localparam logic [1:0]  MUTE_FRAMES = 2'h2;   // settle after change
	// ----------------------------------------------------------------
	// control port map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] FMT_OFS  = 8'h04;     // format control
	localparam logic [7:0] STAT_OFS = 8'h08;     // status, w1 clears
	localparam int F_FMT  = 0;                   // [1:0] format
	localparam int F_WL   = 2;                   // [3:2] word length
	localparam int F_MAN  = 4;                   // [4] auto rate off
	localparam int F_RATE = 5;                   // [6:5] manual rate
	localparam logic [6:0] FMT_RST = 7'h08;      // i2s, 24 bit, auto
	localparam int S_ERR   = 0;                  // [2:0] sticky errors
	localparam int S_RATE  = 3;                  // [4:3] detected rate
	localparam int S_RATIO = 5;                  // [7:5] master ratio
	localparam int S_OSC   = 8;                  // [8] pll on osc
	localparam int E_FRM = 0;
	localparam int E_BCK = 1;
	localparam int E_MCK = 2;
endpackage

// ==== core/aip_if.sv ====
/*
 * aip_if: the audio link between clock source and the port.
 * assumes: the bench joins aip_source and aip_device through it.
 */
`timescale 1ns/1ps
interface aip_if;
	logic audioMclk;        // master clock from the source
	logic bitClk;           // bit clock from the source
	logic frameClk;         // frame clock, one frame per sample
	logic serialInOne;      // serial data line 1
	logic serialInTwo;      // serial data line 2
	logic serialInThree;    // serial data line 3
	logic serialInPassthru; // serial data line 4
	logic serialLineOut;    // i2s line out of the device
	modport src (output audioMclk, bitClk, frameClk, serialInOne,
		serialInTwo, serialInThree, serialInPassthru,
		input serialLineOut);
	modport dev (input audioMclk, bitClk, frameClk, serialInOne,
		serialInTwo, serialInThree, serialInPassthru,
		output serialLineOut);
endinterface

// ==== core/aip_source.sv ====
/*
 * aip_source: upstream audio source driving clocks and four lines.
 * assumes: mclk at 20 MHz; bit clock is mclk/8, master clock mclk/2.
 */
`timescale 1ns/1ps
module aip_source
	import aip_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	aip_if.src                     lnk,
	input  wire logic              clkRun,    // low stops all clocks
	input  wire logic [1:0]        fmtSel,    // aip_fmt_e code
	input  wire logic [1:0]        wlSel,     // word length code
	input  wire logic              bit48,     // 48 fs bit clock
	input  wire logic [3:0][23:0]  leftWord,  // left, msb aligned
	input  wire logic [3:0][23:0]  rightWord, // right, msb aligned
	output logic                   wordTaken  // words latched, pulse
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             mck;    // master clock level
		logic [2:0]       ph;     // bit clock phase
		logic [5:0]       idx;    // bit of the half frame
		logic             lvl;    // frame clock level
		logic [3:0]       dat;    // data lines
		logic [3:0][23:0] wl;     // latched left words
		logic [3:0][23:0] wr;     // latched right words
		logic             tk;     // taken pulse
	} aip_src_s;
	aip_src_s st_reg, st_next;
	logic [5:0] halfLen;          // bits per half frame
	logic [5:0] wlen;             // bits per word
	logic       isLeft;           // new half carries left
	logic [5:0] pos;              // word bit position, msb first
	logic       inWord;           // position holds data
	logic       spill;            // i2s bit owed to the last half
	logic [3:0][23:0] wSrc;       // words feeding this bit
	// ----------------------------------------------------------------
	// next state: clocks, framing, data
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.tk = 1'b0;
		halfLen = bit48 ? 6'd24 : 6'd32;
		wlen = (wlSel == WL_16) ? 6'd16 : (wlSel == WL_20) ? 6'd20 : 6'd24;
		isLeft = 1'b0;
		pos = 6'h00;
		inWord = 1'b0;
		spill = 1'b0;
		wSrc = '0;
		// [RULE1] source makes every clock
		if (clkRun) begin
			st_next.mck = ~st_reg.mck;
			st_next.ph = st_reg.ph + 3'd1;
			// change lines in the same cycle as the bit clock falls
			if (st_reg.ph == 3'd7) begin
				// [RULE2] 64 or 48 bits per frame
				if (st_reg.idx >= halfLen - 6'd1) begin
					st_next.idx = 6'h00;
					st_next.lvl = ~st_reg.lvl;
				end else begin
					st_next.idx = st_reg.idx + 6'd1;
				end
				// [RULE16] i2s left is frame low
				isLeft = (fmtSel == FMT_I2S) ? ~st_next.lvl : st_next.lvl;
				// [RULE17] [RULE18] msb timing per format
				case (fmtSel)
				FMT_I2S: pos = (st_next.idx == 6'h00) ? halfLen - 6'd1
				                                      : st_next.idx - 6'd1;
				FMT_LJ:  pos = st_next.idx;
				FMT_RJ:  pos = st_next.idx - (halfLen - wlen);
				default: pos = st_next.idx;
				endcase
				inWord = (pos < wlen);
				// [RULE16] a 48 fs 24 bit i2s lsb spills past the edge
				spill = (fmtSel == FMT_I2S) && (st_next.idx == 6'h00);
				if (isLeft && st_next.idx == 6'h00) begin
					st_next.wl = leftWord;
					st_next.wr = rightWord;
					st_next.tk = 1'b1;
				end
				// the spilled bit belongs to the word of the last half
				if (spill) wSrc = isLeft ? st_reg.wr : st_reg.wl;
				else wSrc = isLeft ? st_next.wl : st_next.wr;
				for (int i = 0; i < 4; i++) begin
					st_next.dat[i] = inWord & wSrc[i][5'd23 - pos[4:0]];
				end
			end
		end
	end
	// registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// ----------------------------------------------------------------
	// link pins
	// ----------------------------------------------------------------
	assign lnk.audioMclk        = st_reg.mck;
	assign lnk.bitClk           = st_reg.ph[2];
	assign lnk.frameClk         = st_reg.lvl;
	assign lnk.serialInOne      = st_reg.dat[0];
	assign lnk.serialInTwo      = st_reg.dat[1];
	assign lnk.serialInThree    = st_reg.dat[2];
	assign lnk.serialInPassthru = st_reg.dat[3];
	assign wordTaken            = st_reg.tk;
endmodule

// ==== core/aip_device.sv ====
/*
 * aip_device: clock checks, rate detection, serial input capture
 * and the i2s line out of the audio port.
 * assumes: mclk is the internal reference; link pins are asynchronous
 * and slow enough to be seen at 20 MHz.
 */
`timescale 1ns/1ps
// Behaviour
// [RULE1] device is slave to source clocks
// [RULE2] source: 64 fs bit clock, 48 limited
// [RULE3] bit clock must be 64 or 48
// [RULE4] 64 fs master only at quad rate
// [RULE5] pll falls back to oscillator reference
// [RULE6] rate class detected or written manually
// [RULE7] software sets rate for am, de-emphasis
// [RULE8] detect clock errors and master ratio
// [RULE9] software trims oscillator after reset
// [RULE10] lines one to three feed processing
// [RULE11] 16/20/24 bit, three framings
// [RULE12] line out is 24 bit i2s
// [RULE13] line out latency one to 2.5 frames
// [RULE14] line out always runs, no settings
// [RULE15] format held in register 0x04
// [RULE16] i2s: left low, msb one late
// [RULE17] left-justified: left high, msb at edge
// [RULE18] right-justified: lsb before edge, lead masked
// [RULE19] sticky per-clock error flags
// [RULE20] zero samples while clocks are bad
module aip_device
	import aip_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	aip_if.dev                         lnk,
	input  wire logic [7:0]            regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic [31:0]                regRdata,
	input  wire logic                  passSourceSel, // 1: downmix
	input  wire logic [1:0][23:0]      mixIn,         // downmix l/r
	output logic [2:0][1:0][23:0]      sampleOut,     // lines 1-3
	output logic                       sampleStrobe,  // frame done
	output logic [1:0]                 rateClass,     // rate in use
	output logic [2:0]                 ratioCode,     // master ratio
	output logic                       pllRefIsOsc    // pll on osc
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// word length in bits
	function automatic logic [5:0] wlBits(input logic [1:0] c);
		wlBits = (c == WL_16) ? 6'd16 : (c == WL_20) ? 6'd20 : 6'd24;
	endfunction
	// master edges per half frame to ratio code, 0 if unknown
	function automatic logic [2:0] ratioOf(input logic [8:0] n);
		ratioOf = 3'h0;
		for (int k = 1; k <= 6; k++) begin
			logic [8:0] h;
			h = (k < 4) ? 9'(32 * k) : 9'(64 * (k - 2));
			if (n + 9'd1 >= h && n <= h + 9'd1) begin
				ratioOf = 3'(k);
			end
		end
	endfunction
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] pinRaw;           // raw link pins
	logic [6:0] syA;              // first stage, read by syB only
	logic [6:0] syB;              // second stage
	logic [6:0] syC;              // previous synced value
	assign pinRaw = {lnk.serialInPassthru, lnk.serialInThree,
		lnk.serialInTwo, lnk.serialInOne, lnk.frameClk, lnk.bitClk,
		lnk.audioMclk};
	// two flops per pin, third for edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syA <= 7'h00;
			syB <= 7'h00;
			syC <= 7'h00;
		end else begin
			syA <= pinRaw;
			syB <= syA;
			syC <= syB;
		end
	end
	logic       mckRise;          // master clock rose
	logic       bckRise;          // bit clock rose
	logic       bckFall;          // bit clock fell
	logic       frmEdge;          // frame clock changed
	logic [3:0] din;              // synced data lines
	assign mckRise = syB[0] & ~syC[0];
	assign bckRise = syB[1] & ~syC[1];
	assign bckFall = ~syB[1] & syC[1];
	assign frmEdge = syB[2] ^ syC[2];
	assign din     = syB[6:3];
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0]             bIdx;    // bit clocks in this half
		logic [5:0]             halfLen; // last half length
		logic [10:0]            refCnt;  // ref cycles in this half
		logic [8:0]             mckCnt;  // master edges this half
		logic [10:0]            mckIdle; // cycles since master edge
		logic [10:0]            bckIdle; // cycles since bit edge
		logic                   seen;    // a frame edge was seen
		logic [2:0]             errLive; // current clock errors
		logic [2:0]             errStk;  // sticky errors
		logic [1:0]             rate;    // detected rate
		logic [2:0]             ratio;   // detected ratio
		logic [1:0]             muteCnt; // frames left to mute
		logic [3:0][23:0]       sh;      // input shifters
		logic [3:0][1:0][23:0]  smp;     // captured samples
		logic                   stb;     // frame captured
		logic [23:0]            oWord;   // line out shifter
		logic [4:0]             oCnt;    // line out bit count
		logic                   sOut;    // line out level
		logic                   capPend; // i2s capture waits a bit
		logic                   endLeft; // half awaiting capture
		logic [6:0]             fmtReg;  // format control
		logic [31:0]            rd;      // read data
	} aip_dev_s;
	aip_dev_s st_reg, st_next;
	logic [1:0]  fmt;             // format in use
	logic [5:0]  wlen;            // word length in use
	logic [1:0]  rateUse;         // rate class in use
	logic        leftEnd;         // half that ended was left
	logic        inWin;           // current bit is in the word
	logic        badClk;          // clocks not valid now
	logic [1:0]  rateNew;         // rate measured this half
	logic [2:0]  ratioNew;        // ratio measured this half
	logic [2:0]  errNew;          // errors measured this half
	logic [23:0] word;            // aligned captured word
	logic [31:0] stat;            // status word
	logic        capNow;          // capture a half now
	logic        capLeft;         // half captured is left
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.stb = 1'b0;
		st_next.rd = 32'h0000_0000;
		// [RULE15] framing from the format register
		fmt = st_reg.fmtReg[F_FMT +: 2];
		wlen = wlBits(st_reg.fmtReg[F_WL +: 2]);
		// [RULE6] manual rate overrides detection
		rateUse = st_reg.fmtReg[F_MAN] ? st_reg.fmtReg[F_RATE +: 2]
		                               : st_reg.rate;
		leftEnd = (fmt == FMT_I2S) ? ~syC[2] : syC[2];
		rateNew = RATE_QUAD;
		ratioNew = ratioOf(st_reg.mckCnt);
		errNew = 3'h0;
		word = 24'h00_0000;
		capNow = (fmt == FMT_I2S) ? (st_reg.capPend & bckRise) : frmEdge;
		capLeft = (fmt == FMT_I2S) ? st_reg.endLeft : leftEnd;
		badClk = (st_reg.errLive != 3'h0) || (st_reg.muteCnt != 2'h0);
		stat = {23'h00_0000, st_reg.errLive[E_MCK], st_reg.ratio,
			st_reg.rate, st_reg.errStk};
		// [RULE16] [RULE17] [RULE18] word window per format
		case (fmt)
		FMT_I2S: inWin = st_reg.capPend ? (st_reg.halfLen <= wlen)
			: (st_reg.bIdx >= 6'd1 && st_reg.bIdx <= wlen);
		FMT_LJ:  inWin = st_reg.bIdx < wlen;
		FMT_RJ:  inWin = st_reg.bIdx >= st_reg.halfLen - wlen;
		default: inWin = 1'b0;
		endcase
		// [RULE8] reference counts and idle timeouts
		if (st_reg.refCnt != 11'h7FF) st_next.refCnt = st_reg.refCnt + 11'd1;
		if (st_reg.mckIdle != 11'h7FF) st_next.mckIdle = st_reg.mckIdle + 11'd1;
		if (st_reg.bckIdle != 11'h7FF) st_next.bckIdle = st_reg.bckIdle + 11'd1;
		if (mckRise) begin
			st_next.mckIdle = 11'h000;
			if (st_reg.mckCnt != 9'h1FF) st_next.mckCnt = st_reg.mckCnt + 9'd1;
		end
		if (bckRise) begin
			st_next.bckIdle = 11'h000;
			st_next.bIdx = st_reg.bIdx + 6'd1;
			// [RULE11] shift only the bits of the word
			for (int i = 0; i < 4; i++) begin
				if (inWin) st_next.sh[i] = {st_reg.sh[i][22:0], din[i]};
			end
		end
		if (st_reg.mckIdle >= 11'(MCK_TMO_CYC)) st_next.errLive[E_MCK] = 1'b1;
		if (st_reg.bckIdle >= 11'(BCK_TMO_CYC)) st_next.errLive[E_BCK] = 1'b1;
		if (st_reg.refCnt >= 11'(FRM_TMO_CYC)) st_next.errLive[E_FRM] = 1'b1;
		// line out: one bit per falling bit clock, msb one late
		if (bckFall && !frmEdge) begin
			st_next.sOut = (st_reg.oCnt < 5'd24) & st_reg.oWord[23];
			st_next.oWord = {st_reg.oWord[22:0], 1'b0};
			if (st_reg.oCnt != 5'h1F) st_next.oCnt = st_reg.oCnt + 5'd1;
		end
		if (frmEdge) begin
			// [RULE6] rate class from half frame length
			if (st_reg.refCnt > HALF_32K) rateNew = RATE_32K;
			else if (st_reg.refCnt > HALF_NORM) rateNew = RATE_NORM;
			else if (st_reg.refCnt > HALF_DBL) rateNew = RATE_DBL;
			// [RULE3] only 32 or 24 bits per half
			errNew[E_BCK] = st_reg.bIdx != 6'd32 && st_reg.bIdx != 6'd24;
			// [RULE4] ratio 64 only at quad rate
			errNew[E_MCK] = (ratioNew == 3'h0) ||
				(ratioNew == 3'h1 && rateNew != RATE_QUAD);
			if (st_reg.seen) begin
				st_next.errLive = errNew;
				st_next.ratio = ratioNew;
				st_next.rate = rateNew;
				if (!errNew[E_BCK]) st_next.halfLen = st_reg.bIdx;
				// [RULE20] mute while settling after change
				if (rateNew != st_reg.rate) st_next.muteCnt = MUTE_FRAMES;
				else if (st_reg.muteCnt != 2'h0 && !leftEnd)
					st_next.muteCnt = st_reg.muteCnt - 2'd1;
			end
			st_next.seen = 1'b1;
			st_next.refCnt = 11'h000;
			st_next.mckCnt = 9'h000;
			st_next.bIdx = 6'h00;
			// [RULE16] i2s capture waits for the bit after the edge
			st_next.capPend = (fmt == FMT_I2S);
			st_next.endLeft = leftEnd;
			// [RULE12] [RULE13] [RULE14] 24 bit i2s, left on low
			// a 48 fs word sends its lsb on the edge itself
			st_next.sOut = (st_reg.oCnt < 5'd24) & st_reg.oWord[23];
			st_next.oCnt = 5'h00;
			st_next.oWord = passSourceSel ? mixIn[syB[2] ? 1 : 0]
			                : st_reg.smp[3][syB[2] ? 1 : 0];
			// [RULE10] line four goes to line out only
			if (badClk) st_next.oWord = 24'h00_0000;
		end
		// capture, left aligned, zero while clocks bad
		if (capNow) begin
			for (int i = 0; i < 4; i++) begin
				word = st_next.sh[i] << (6'd24 - wlen);
				// [RULE20] zero samples downstream
				if (badClk) word = 24'h00_0000;
				st_next.smp[i][capLeft ? 0 : 1] = word;
			end
			st_next.sh = '0;
			st_next.capPend = 1'b0;
			st_next.stb = ~capLeft;
		end
		// [RULE20] no stale samples or line level on dead clocks
		if (st_reg.errLive != 3'h0) st_next.smp = '0;
		if (st_reg.bckIdle >= 11'(BCK_TMO_CYC)) st_next.sOut = 1'b0;
		// [RULE19] sticky flags, set wins over clear
		if (regWr && regAddr == STAT_OFS)
			st_next.errStk = st_reg.errStk & ~regWdata[2:0];
		st_next.errStk = st_next.errStk | st_reg.errLive;
		if (regWr && regAddr == FMT_OFS) st_next.fmtReg = regWdata[6:0];
		// read: data one cycle later, unmapped reads zero
		if (regRd) begin
			case (regAddr)
			FMT_OFS:  st_next.rd = {25'h000_0000, st_reg.fmtReg};
			STAT_OFS: st_next.rd = stat;
			default:  st_next.rd = 32'h0000_0000;
			endcase
		end
	end
	// registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.fmtReg <= FMT_RST;
			st_reg.halfLen <= 6'd32;
			st_reg.rate <= RATE_NORM;
		end else begin
			st_reg <= st_next;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign regRdata = st_reg.rd;
	assign sampleOut = st_reg.smp[2:0];
	assign sampleStrobe = st_reg.stb;
	assign rateClass = rateUse;
	assign ratioCode = st_reg.ratio;
	// [RULE5] oscillator reference while master clock bad
	assign pllRefIsOsc = st_reg.errLive[E_MCK];
	assign lnk.serialLineOut = st_reg.sOut;
endmodule

// ==== bench/aip_properties.sv ====
/*
 * aip_properties: timing checks on the audio link between both ends.
 * assumes: instantiated beside the link; mclk is the 20 MHz clock.
 */
`timescale 1ns/1ps
module aip_properties (
	input wire logic mclk,             // reference clock
	input wire logic rst_n,            // async reset, active low
	input wire logic audioMclk,        // master clock on the link
	input wire logic bitClk,           // bit clock on the link
	input wire logic frameClk,         // frame clock on the link
	input wire logic serialInOne,      // data line one
	input wire logic serialInPassthru, // data line four
	input wire logic serialLineOut     // i2s line out
);
	// ----------------------------------------------------------------
	// helper: cycles since the bit clock last moved
	// ----------------------------------------------------------------
	logic       bitPrev_reg;  // bit clock one cycle ago
	logic [7:0] idleCnt_reg;  // saturating idle count
	logic [7:0] idleCnt_next; // next idle count
	// count up while the bit clock holds still
	always_comb begin
		if (bitClk != bitPrev_reg) begin
			idleCnt_next = 8'h00;
		end else if (idleCnt_reg != 8'hFF) begin
			idleCnt_next = idleCnt_reg + 8'h01;
		end else begin
			idleCnt_next = idleCnt_reg;
		end
	end
	// register the helper state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bitPrev_reg <= 1'b0;
			idleCnt_reg <= 8'h00;
		end else begin
			bitPrev_reg <= bitClk;
			idleCnt_reg <= idleCnt_next;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_bitFall;
		$fell(bitClk);
	endsequence
	property p_frameAtFall;
		$changed(frameClk) |-> s_bitFall;
	endproperty
	property p_lineAtFall;
		$changed(serialInOne) |-> s_bitFall;
	endproperty
	property p_fourLowClk;
		$changed(serialInPassthru) |-> !bitClk;
	endproperty
	property p_outBitWidth;
		$changed(serialLineOut) |=> $stable(serialLineOut)[*6];
	endproperty
	property p_slaveClocks;
		$changed(bitClk) |-> $changed(audioMclk);
	endproperty
	property p_halfFrame;
		$changed(frameClk) |=> $stable(frameClk)[*8];
	endproperty
	property p_bitLowHalf;
		s_bitFall |=> !bitClk[*3];
	endproperty
	property p_muteIdle;
		idleCnt_reg >= 8'd100 |-> !serialLineOut;
	endproperty
	a_frameAtFall: assert property (p_frameAtFall)
		else $error("frame clock moved off a bit clock fall");
	a_lineAtFall: assert property (p_lineAtFall)
		else $error("data line moved off a bit clock fall");
	a_fourLowClk: assert property (p_fourLowClk)
		else $error("line four moved while bit clock high");
	a_outBitWidth: assert property (p_outBitWidth)
		else $error("line out bit shorter than a bit period");
	a_slaveClocks: assert property (p_slaveClocks)
		else $error("bit clock moved without master clock");
	a_halfFrame: assert property (p_halfFrame)
		else $error("frame half far too short");
	a_bitLowHalf: assert property (p_bitLowHalf)
		else $error("bit clock low phase too short");
	a_muteIdle: assert property (p_muteIdle)
		else $error("line out not zero with clocks stopped");
endmodule

// ==== bench/testbench.sv ====
/*
 * testbench: scenario tasks for the audio source and port pair.
 * assumes: both ends meet in aip_if and run on the 20 MHz mclk.
 */
`timescale 1ns/1ps
module testbench
	import aip_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic                  mclk, rst_n, clkRun, bit48, wordTaken;
	logic [1:0]            fmtSel, wlSel, rateClass;
	logic [3:0][23:0]      leftWord, rightWord;  // source words
	logic [7:0]            regAddr;
	logic [31:0]           regWdata, regRdata, d;
	logic                  regWr, regRd, passSourceSel, sampleStrobe;
	logic [1:0][23:0]      mixIn;                // downmix words
	logic [2:0][1:0][23:0] sampleOut;
	logic [2:0]            ratioCode;
	logic                  pllRefIsOsc;
	int                    n_mismatch, n_tests, cycles;
	aip_if lnk();
	aip_source u_aip_source (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
		.clkRun(clkRun), .fmtSel(fmtSel), .wlSel(wlSel), .bit48(bit48),
		.leftWord(leftWord), .rightWord(rightWord), .wordTaken(wordTaken));
	aip_device u_aip_device (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .passSourceSel(passSourceSel),
		.mixIn(mixIn), .sampleOut(sampleOut), .sampleStrobe(sampleStrobe),
		.rateClass(rateClass), .ratioCode(ratioCode),
		.pllRefIsOsc(pllRefIsOsc));
	aip_properties u_aip_properties (.mclk(mclk), .rst_n(rst_n),
		.audioMclk(lnk.audioMclk), .bitClk(lnk.bitClk),
		.frameClk(lnk.frameClk), .serialInOne(lnk.serialInOne),
		.serialInPassthru(lnk.serialInPassthru),
		.serialLineOut(lnk.serialLineOut));
	// ----------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------
	always #25 mclk = ~mclk;
	// cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	// keep only the programmed word length
	function automatic logic [23:0] msk(logic [23:0] v, logic [1:0] w);
		if (w == WL_16) return v & 24'hFF_FF00;
		if (w == WL_20) return v & 24'hFF_FFF0;
		return v;
	endfunction
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(FMT_OFS, d);
		chk(d, {25'h0, FMT_RST});
		wr(FMT_OFS, 32'h0000_0070);
		@(posedge mclk);
		#1 chk(32'(rateClass), 32'(RATE_QUAD));
		rd(8'h0C, d);
		chk(d, 32'h0000_0000);
		wr(FMT_OFS, 32'h0000_0008);
	endtask
	task automatic t_fmt(input logic [1:0] f, input logic [1:0] w,
		input logic b);
		@(posedge mclk);
		fmtSel <= f;
		wlSel <= w;
		bit48 <= b;
		wr(FMT_OFS, 32'({w, f}));
		repeat (4) @(posedge mclk iff sampleStrobe);
		#1;
		for (int i = 0; i < 3; i++) begin
			chk(32'(sampleOut[i][0]), 32'(msk(leftWord[i], w)));
			chk(32'(sampleOut[i][1]), 32'(msk(rightWord[i], w)));
		end
		chk(32'(rateClass), 32'(RATE_NORM));
		chk(32'(ratioCode), b ? 32'h0000_0003 : 32'h0000_0004);
		// words are taken as the left half opens
		@(posedge mclk iff wordTaken);
		#1 chk(32'(lnk.frameClk), (f == FMT_I2S) ? 0 : 1);
	endtask
	task automatic t_line(input logic sel);
		logic [24:0] w;
		@(posedge mclk);
		passSourceSel <= sel;
		repeat (1600) @(posedge mclk);
		@(negedge lnk.frameClk);
		@(posedge lnk.bitClk);
		w = '0;
		// the line moves 3 cycles after a fall: fall k shows bit k-1
		for (int k = 1; k <= 26; k++) begin
			@(negedge lnk.bitClk);
			if (k >= 2) w = {w[23:0], lnk.serialLineOut};
		end
		chk(32'(w), 32'({sel ? mixIn[0] : leftWord[3], 1'b0}));
	endtask
	task automatic t_stop();
		clkRun <= 1'b0;
		repeat (1000) @(posedge mclk);
		rd(STAT_OFS, d);
		chk(32'(d[2:0]), 32'h0000_0007);
		chk(32'(pllRefIsOsc), 32'h0000_0001);
		chk(32'(sampleOut[0][0]), 32'h0000_0000);
		clkRun <= 1'b1;
		repeat (2000) @(posedge mclk);
		rd(STAT_OFS, d);
		chk(32'(d[2:0]), 32'h0000_0007);
		wr(STAT_OFS, 32'h0000_0007);
		rd(STAT_OFS, d);
		chk(32'(d[2:0]), 32'h0000_0000);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{clkRun, bit48, regWr, regRd, passSourceSel} = '0;
		{fmtSel, wlSel, regAddr, regWdata} = '0;
		for (int i = 0; i < 4; i++) begin
			leftWord[i] = 24'h9B_3C7E ^ 24'(i * 24'h11_1111);
			rightWord[i] = ~leftWord[i];
		end
		mixIn = {24'h3D_5A17, 24'hC6_0E99};
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1; // mclk stands for a trimmed reference
		clkRun <= 1'b1;
		t_regs();
		for (int f = 0; f < 3; f++) begin
			for (int w = 0; w < 3; w++) t_fmt(2'(f), 2'(w), 1'b0);
			t_fmt(2'(f), WL_24, 1'b1);
		end
		t_fmt(2'(FMT_I2S), WL_24, 1'b0);
		t_line(1'b0);
		t_line(1'b1);
		t_stop();
		stop_test();
	end
endmodule
